// [design/upsid_top.sv]
`include "upsid_consts.svh"

// Operation
// - chip reset low keeps both regulators off with weak pull-downs on.
// - reset held low at least 1 us then raised restores defaults everywhere.
// - registers take their default values while the core supply comes up.
// - internal reset pulse after core supply stable, then normal operation starts.
// - off, reset mode or full operation from battery, io supply and reset.
// - default operating state after power-up is synchronous mode.
// - operation starts only with supplies stable, reference clock present, reset high.
// - with supplies stable apply data pull-downs and hold DIR until PLL lock.
// - after lock, STP low releases DIR; STP high keeps DIR high.
// - start-up interval counts from reference clock start, assuming STP low.
// - in UART mode a two-bit field selects the 3.3 V regulator level.
// - grounded status reads 0 for A plug, 1 for floating B plug.
// - pull-up cleared: weak pull-up holds line; grounding it raises an event.
// - resistance code 000, 001, 010, 011 or 101 with pull-up disabled.
// - resistance code readable only in synchronous mode.
module upsid_top #(
   parameter int POR_CYC     = `UPSID_POR_CYC,
   parameter int REF_TIMEOUT = `UPSID_REF_TIMEOUT
)
(
   // clock and reset
   input  wire logic                  MCLK,
   input  wire logic                  SYS_RST,
   // axi4-lite write
   input  wire logic [11:0]           S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   output logic [1:0]                 S_AXI_BRESP,
   output logic                       S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   // axi4-lite read
   input  wire logic [11:0]           S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   output logic [31:0]                S_AXI_RDATA,
   output logic [1:0]                 S_AXI_RRESP,
   output logic                       S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY,
   // pins and supply monitors
   input  wire logic                  CHIP_RESET_INPUT_N,
   input  wire logic                  REFERENCE_CLOCK_INPUT,
   input  wire logic                  VBAT_PRESENT,
   input  wire logic                  IO_SUPPLY,
   input  wire logic                  CORE_SUPPLY_STABLE,
   input  wire logic                  SUPPLY_3V3_STABLE,
   input  wire logic                  PLL_LOCK,
   input  wire logic                  STP,
   input  wire logic                  ID_CMP_HIGH,
   input  wire logic [2:0]            RID_CODE,
   // outputs
   output logic                       REG_ENABLE,
   output logic                       REG_WEAK_PULLDOWN,
   output upsid_pkg::upsid_level_t    UART_SUPPLY_LEVEL_SEL,
   output logic                       PINS_HIZ,
   output logic                       DATA_PULLDOWN_EN,
   output logic                       DIR,
   output logic                       CABLE_ID_PULLUP_EN,
   output logic                       WEAK_ID_PULLUP,
   output logic                       ID_GND_EVENT,
   output logic                       SYNC_MODE
);
   import upsid_pkg::*;

   localparam int RST_MIN_CYC = `UPSID_RST_MIN_CYC;

   generate
      if (POR_CYC < 1 || POR_CYC > 255 || REF_TIMEOUT < 2 || REF_TIMEOUT > 255)
      begin : g_chk
         $error("upsid_top: POR_CYC or REF_TIMEOUT out of range");
      end
   endgenerate

   // synchronised pins
   logic [11:0]  pins_s;
   logic         rstn_s;
   logic         ref_s;
   logic         vbat_s;
   logic         io_s;
   logic         core_s;
   logic         s33_s;
   logic         lock_s;
   logic         stp_s;
   logic         id_s;
   logic [2:0]   rid_s;

   upsid_sync #(.W(12)) u_sync
   (
      .clk (MCLK),
      .rst (SYS_RST),
      .d   ({RID_CODE, ID_CMP_HIGH, STP, PLL_LOCK, SUPPLY_3V3_STABLE, CORE_SUPPLY_STABLE,
             IO_SUPPLY, VBAT_PRESENT, REFERENCE_CLOCK_INPUT, CHIP_RESET_INPUT_N}),
      .q   (pins_s)
   );

   assign {rid_s, id_s, stp_s, lock_s, s33_s, core_s, io_s, vbat_s, ref_s, rstn_s} = pins_s;

   // chip reset qualification
   logic [7:0]   low_cnt_ff;
   logic         rst_req_ff;

   // glitches shorter than the minimum do not reset state
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || rstn_s)
         low_cnt_ff <= 8'h00;
      else if (low_cnt_ff < 8'(RST_MIN_CYC))
         low_cnt_ff <= low_cnt_ff + 8'h01;
   end

   // released on the clock, so all state leaves reset together
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         rst_req_ff <= 1'b1;
      else if (rstn_s)
         rst_req_ff <= 1'b0;
      else if (low_cnt_ff >= 8'(RST_MIN_CYC) - 8'h01)
         rst_req_ff <= 1'b1;
   end

   // reference clock presence, sampled like any pin
   logic         ref_prev_ff;
   logic [7:0]   ref_age_ff;
   logic         ref_present;

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         ref_prev_ff <= 1'b0;
         ref_age_ff  <= 8'(REF_TIMEOUT);
      end
      else
      begin
         ref_prev_ff <= ref_s;
         if (ref_s && !ref_prev_ff)
            ref_age_ff <= 8'h00;
         else if (ref_age_ff < 8'(REF_TIMEOUT))
            ref_age_ff <= ref_age_ff + 8'h01;
      end
   end

   // no timing tie between reset and reference edges is assumed
   assign ref_present = (ref_age_ff < 8'(REF_TIMEOUT));

   // start-up sequencer
   upsid_state_t state_ff;
   upsid_state_t nxt_state;
   logic [7:0]   por_cnt_ff;
   logic         dir_ff;
   logic         nxt_dir;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         UPSID_ST_OFF:
            if (vbat_s)
               nxt_state = UPSID_ST_RESET;
         UPSID_ST_RESET:
            if (rstn_s && !rst_req_ff)
               nxt_state = UPSID_ST_POWER_UP;
         UPSID_ST_POWER_UP:
            if (core_s && s33_s)
               nxt_state = UPSID_ST_POR;
         UPSID_ST_POR:
            if (por_cnt_ff == 8'(POR_CYC - 1))
               nxt_state = UPSID_ST_REF_WAIT;
         UPSID_ST_REF_WAIT:
            if (ref_present)
               nxt_state = UPSID_ST_LOCK_WAIT;
         UPSID_ST_LOCK_WAIT:
            if (lock_s)
               nxt_state = UPSID_ST_STP_CHECK;
         UPSID_ST_STP_CHECK:
            if (!stp_s)
               nxt_state = UPSID_ST_SYNC;
         UPSID_ST_SYNC:
            nxt_state = UPSID_ST_SYNC;
         default:
            nxt_state = UPSID_ST_OFF;
      endcase
      if (!vbat_s)
         nxt_state = UPSID_ST_OFF;
      else if (rst_req_ff)
         nxt_state = UPSID_ST_RESET;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         state_ff <= UPSID_ST_OFF;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || state_ff != UPSID_ST_POR)
         por_cnt_ff <= 8'h00;
      else
         por_cnt_ff <= por_cnt_ff + 8'h01;
   end

   // dir high from supplies stable until lock and stp released
   assign nxt_dir = (nxt_state == UPSID_ST_POR) || (nxt_state == UPSID_ST_REF_WAIT) ||
                    (nxt_state == UPSID_ST_LOCK_WAIT) || (nxt_state == UPSID_ST_STP_CHECK);

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         dir_ff <= 1'b0;
      else
         dir_ff <= nxt_dir;
   end

   // start-up interval, counted only once the reference runs
   logic [15:0]  start_cnt_ff;

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || state_ff == UPSID_ST_RESET || state_ff == UPSID_ST_OFF)
         start_cnt_ff <= 16'h0000;
      else if (state_ff != UPSID_ST_SYNC && ref_present && start_cnt_ff != 16'hFFFF)
         start_cnt_ff <= start_cnt_ff + 16'h0001;
   end

   // software registers, cleared by any reset or power-up phase
   logic         regs_clr;
   logic         pullup_ff;
   upsid_level_t lvl_ff;
   logic         uart_ff;
   logic         wr_go;
   logic         rd_go;
   logic         bvalid_ff;
   logic [1:0]   bresp_ff;
   logic         rvalid_ff;
   logic [1:0]   rresp_ff;
   logic [31:0]  rdata_ff;
   logic [31:0]  status_word;
   logic [2:0]   rid_view;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `UPSID_OFS_CTRL) || (a == `UPSID_OFS_STATUS);
   endfunction

   assign regs_clr = (state_ff == UPSID_ST_OFF) || (state_ff == UPSID_ST_RESET) ||
                     (state_ff == UPSID_ST_POWER_UP) || (state_ff == UPSID_ST_POR);
   assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_ff;
   assign rd_go = S_AXI_ARVALID && !rvalid_ff;

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || regs_clr)
      begin
         pullup_ff <= `UPSID_RST_PULLUP;
         lvl_ff    <= `UPSID_RST_LVL;
         uart_ff   <= `UPSID_RST_UART;
      end
      else if (wr_go && S_AXI_AWADDR == `UPSID_OFS_CTRL && S_AXI_WSTRB[0])
      begin
         pullup_ff <= S_AXI_WDATA[`UPSID_CTRL_PULLUP];
         lvl_ff    <= S_AXI_WDATA[`UPSID_CTRL_LVL_LSB +: 2];
         uart_ff   <= S_AXI_WDATA[`UPSID_CTRL_UART];
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `UPSID_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= is_mapped(S_AXI_AWADDR) ? `UPSID_RESP_OKAY : `UPSID_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         bvalid_ff <= 1'b0;
   end

   // code hidden outside synchronous mode or with the pull-up on
   assign rid_view = (state_ff == UPSID_ST_SYNC && !pullup_ff) ? rid_s : 3'h0;

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[`UPSID_ST_GND] = id_s;
      status_word[`UPSID_ST_RID_LSB +: 3] = rid_view;
      status_word[`UPSID_ST_SYNC] = (state_ff == UPSID_ST_SYNC);
      status_word[`UPSID_ST_DIR] = dir_ff;
      status_word[`UPSID_ST_STATE_LSB +: 8] = state_ff;
      status_word[`UPSID_ST_START_LSB +: 16] = start_cnt_ff;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= `UPSID_RESP_OKAY;
         rdata_ff  <= 32'h0000_0000;
      end
      else if (rd_go)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= is_mapped(S_AXI_ARADDR) ? `UPSID_RESP_OKAY : `UPSID_RESP_SLVERR;
         case (S_AXI_ARADDR)
            `UPSID_OFS_CTRL:
               rdata_ff <= {28'h000_0000, uart_ff, lvl_ff, pullup_ff};
            `UPSID_OFS_STATUS:
               rdata_ff <= status_word;
            default:
               rdata_ff <= 32'h0000_0000;
         endcase
      end
      else if (S_AXI_RREADY)
         rvalid_ff <= 1'b0;
   end

   // grounding event while only the weak pull-up holds the line
   logic id_prev_ff;
   logic evt_ff;

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         id_prev_ff <= 1'b1;
         evt_ff     <= 1'b0;
      end
      else
      begin
         id_prev_ff <= id_s;
         evt_ff     <= id_prev_ff && !id_s && !pullup_ff && !regs_clr;
      end
   end

   // outputs
   assign S_AXI_AWREADY         = wr_go;
   assign S_AXI_WREADY          = wr_go;
   assign S_AXI_BVALID          = bvalid_ff;
   assign S_AXI_BRESP           = bresp_ff;
   assign S_AXI_ARREADY         = rd_go;
   assign S_AXI_RVALID          = rvalid_ff;
   assign S_AXI_RRESP           = rresp_ff;
   assign S_AXI_RDATA           = rdata_ff;
   assign REG_ENABLE            = rstn_s && vbat_s;
   assign REG_WEAK_PULLDOWN     = !(rstn_s && vbat_s);
   assign UART_SUPPLY_LEVEL_SEL = uart_ff ? lvl_ff : `UPSID_RST_LVL;
   assign PINS_HIZ              = (state_ff == UPSID_ST_RESET) && io_s;
   assign DATA_PULLDOWN_EN      = dir_ff;
   assign DIR                   = dir_ff;
   assign CABLE_ID_PULLUP_EN    = pullup_ff;
   assign WEAK_ID_PULLUP        = !pullup_ff;
   assign ID_GND_EVENT          = evt_ff;
   assign SYNC_MODE             = (state_ff == UPSID_ST_SYNC);

   // checks
   a_reg_off_low: assert property (@(posedge MCLK) disable iff (SYS_RST)
      !rstn_s |-> !REG_ENABLE && REG_WEAK_PULLDOWN) else $error("regulators on with reset low");
   a_short_glitch: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $rose(rst_req_ff) |-> !$past(rstn_s, 39)) else $error("reset accepted before 1 us");
   a_defaults_load: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_ff == UPSID_ST_POR) |=> !pullup_ff && !uart_ff && lvl_ff == 2'h0) else $error("defaults not held");
   // counter based, so the pulse length may be any legal POR_CYC
   a_por_length: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_ff == UPSID_ST_POR) && (por_cnt_ff != 8'(POR_CYC - 1)) && vbat_s && !rst_req_ff
      |=> state_ff == UPSID_ST_POR) else $error("internal reset pulse too short");
   a_hiz_mode: assert property (@(posedge MCLK) disable iff (SYS_RST)
      PINS_HIZ |-> io_s && state_ff == UPSID_ST_RESET) else $error("tristate outside reset mode");
   a_ref_needed: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_ff == UPSID_ST_REF_WAIT) && !ref_present |=> state_ff != UPSID_ST_LOCK_WAIT)
      else $error("left ref wait without clock");
   a_dir_lock: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_ff == UPSID_ST_LOCK_WAIT) && !lock_s && vbat_s && !rst_req_ff |=> DIR && DATA_PULLDOWN_EN)
      else $error("dir dropped before lock");
   a_stp_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_ff == UPSID_ST_STP_CHECK) && stp_s && vbat_s && !rst_req_ff |=> DIR) else $error("dir fell with stp high");
   a_stp_release: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_ff == UPSID_ST_STP_CHECK) && !stp_s && vbat_s && !rst_req_ff |=> !DIR ##1 SYNC_MODE)
      else $error("dir kept with stp low");
   a_uart_level: assert property (@(posedge MCLK) disable iff (SYS_RST)
      !uart_ff |-> UART_SUPPLY_LEVEL_SEL == 2'h0) else $error("level applied outside uart mode");
   a_id_event: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $fell(id_s) && !pullup_ff && !regs_clr |=> ID_GND_EVENT) else $error("grounding event missed");
   a_rid_hidden: assert property (@(posedge MCLK) disable iff (SYS_RST)
      !SYNC_MODE |-> status_word[3:1] == 3'h0) else $error("resistance code visible outside sync");
endmodule

// [design/upsid_consts.svh]
`ifndef UPSID_CONSTS_SVH
`define UPSID_CONSTS_SVH

// timing
`define UPSID_CLK_PERIOD_NS  25
`define UPSID_RST_MIN_NS     1000
`define UPSID_RST_MIN_CYC    ((`UPSID_RST_MIN_NS + `UPSID_CLK_PERIOD_NS - 1) / `UPSID_CLK_PERIOD_NS)
`define UPSID_POR_CYC        16
`define UPSID_REF_TIMEOUT    32

// register byte offsets
`define UPSID_OFS_CTRL       12'h000
`define UPSID_OFS_STATUS     12'h004

// control fields
`define UPSID_CTRL_PULLUP    0
`define UPSID_CTRL_LVL_LSB   1
`define UPSID_CTRL_UART      3

// status fields
`define UPSID_ST_GND         0
`define UPSID_ST_RID_LSB     1
`define UPSID_ST_SYNC        4
`define UPSID_ST_DIR         5
`define UPSID_ST_STATE_LSB   8
`define UPSID_ST_START_LSB   16

// reset values
`define UPSID_RST_LVL        2'h0
`define UPSID_RST_PULLUP     1'b0
`define UPSID_RST_UART       1'b0

// bus responses
`define UPSID_RESP_OKAY      2'h0
`define UPSID_RESP_SLVERR    2'h2

`endif

// [design/upsid_pkg.sv]
package upsid_pkg;
   typedef enum logic [7:0]
   {
      UPSID_ST_OFF       = 8'h01,
      UPSID_ST_RESET     = 8'h02,
      UPSID_ST_POWER_UP  = 8'h04,
      UPSID_ST_POR       = 8'h08,
      UPSID_ST_REF_WAIT  = 8'h10,
      UPSID_ST_LOCK_WAIT = 8'h20,
      UPSID_ST_STP_CHECK = 8'h40,
      UPSID_ST_SYNC      = 8'h80
   } upsid_state_t;

   typedef logic [1:0] upsid_level_t;
endpackage

// [design/upsid_sync.sv]
module upsid_sync #(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   generate
      if (W < 1)
      begin : g_chk
         $error("upsid_sync: width must be at least 1");
      end
   endgenerate

   // first stage read only by the second
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_ff <= '0;
         q_ff    <= '0;
      end
      else
      begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

// [sim/upsid_link_model.sv]
module upsid_link_model
(
   // requests from the bench
   input  wire logic ref_run,
   input  wire logic rst_req_n,
   input  wire logic stp_req,
   // pins toward the block
   output logic      ref_clk,
   output logic      chip_rst_n,
   output logic      stp
);
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_seen;

   // 200 ns reference, free running while enabled
   initial
   begin
      ref_clk = 1'b0;
      ref_seen = 1'b0;
      forever
      begin
         #100;
         ref_clk = ref_run ? ~ref_clk : 1'b0;
         ref_seen = ref_seen | ref_run;
      end
   end

   // always driven; rises only once the reference runs, off-grid to it
   initial
      chip_rst_n = 1'b0;
   always @(rst_req_n, ref_seen)
      chip_rst_n <= #37 (rst_req_n & ref_seen);

   // stop released only when the link can drive idle data
   initial
      stp = 1'b1;
   always @(stp_req)
      stp <= #11 stp_req;
endmodule

// [sim/upsid_top_test.sv]
`include "upsid_consts.svh"

module upsid_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   import upsid_pkg::*;

   localparam logic [11:0] CTRL = `UPSID_OFS_CTRL;
   localparam logic [11:0] STAT = `UPSID_OFS_STATUS;
   localparam logic [1:0]  OK   = `UPSID_RESP_OKAY;
   localparam logic [1:0]  ERR  = `UPSID_RESP_SLVERR;

   // bus and clock
   logic          MCLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic          S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic [11:0]   S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0]   S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0]    S_AXI_WSTRB;
   logic [1:0]    S_AXI_BRESP, S_AXI_RRESP;
   // pins, monitors and outputs
   logic          CHIP_RESET_INPUT_N, REFERENCE_CLOCK_INPUT, STP, VBAT_PRESENT, IO_SUPPLY;
   logic          CORE_SUPPLY_STABLE, SUPPLY_3V3_STABLE, PLL_LOCK, ID_CMP_HIGH;
   logic [2:0]    RID_CODE;
   logic          REG_ENABLE, REG_WEAK_PULLDOWN, PINS_HIZ, DATA_PULLDOWN_EN, DIR;
   logic          CABLE_ID_PULLUP_EN, WEAK_ID_PULLUP, ID_GND_EVENT, SYNC_MODE;
   upsid_level_t  UART_SUPPLY_LEVEL_SEL;
   // link requests and bookkeeping
   logic          ref_run, rst_req_n, stp_req;
   int            n_errors = 0;
   int            tests_run = 0;
   int            n_evt = 0;
   int            snap;
   logic [2:0]    codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};

   upsid_top #(.POR_CYC(4), .REF_TIMEOUT(16)) upsid_top_inst
   (
      .MCLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
      .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
      .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
      .CHIP_RESET_INPUT_N, .REFERENCE_CLOCK_INPUT, .VBAT_PRESENT, .IO_SUPPLY, .CORE_SUPPLY_STABLE,
      .SUPPLY_3V3_STABLE, .PLL_LOCK, .STP, .ID_CMP_HIGH, .RID_CODE, .REG_ENABLE, .REG_WEAK_PULLDOWN,
      .UART_SUPPLY_LEVEL_SEL, .PINS_HIZ, .DATA_PULLDOWN_EN, .DIR, .CABLE_ID_PULLUP_EN,
      .WEAK_ID_PULLUP, .ID_GND_EVENT, .SYNC_MODE
   );

   upsid_link_model upsid_link_model_inst
   (
      .ref_run    (ref_run),
      .rst_req_n  (rst_req_n),
      .stp_req    (stp_req),
      .ref_clk    (REFERENCE_CLOCK_INPUT),
      .chip_rst_n (CHIP_RESET_INPUT_N),
      .stp        (STP)
   );

   initial
   begin
      MCLK = 1'b0;
      forever
         #12.5 MCLK = ~MCLK;
   end

   always @(posedge MCLK)
      if (ID_GND_EVENT === 1'b1)
         n_evt++;

   task automatic end_of_test();
      $display("errors %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_up();
      n_errors++;
      $display("mismatch at %0t ns: bus handshake timed out", $time);
      end_of_test();
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge MCLK);
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      do
      begin
         @(posedge MCLK);
         n++;
      end
      while (S_AXI_AWREADY !== 1'b1 && n < 50);
      S_AXI_AWVALID <= 1'b0;
      S_AXI_WVALID  <= 1'b0;
      do
      begin
         @(posedge MCLK);
         n++;
      end
      while (S_AXI_BVALID !== 1'b1 && n < 100);
      if (n >= 100)
         give_up();
      resp = S_AXI_BRESP;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      do
      begin
         @(posedge MCLK);
         n++;
      end
      while (S_AXI_ARREADY !== 1'b1 && n < 50);
      S_AXI_ARVALID <= 1'b0;
      do
      begin
         @(posedge MCLK);
         n++;
      end
      while (S_AXI_RVALID !== 1'b1 && n < 100);
      if (n >= 100)
         give_up();
      d = S_AXI_RDATA;
      resp = S_AXI_RRESP;
   endtask

   // one spare cycle so the written value shows at the pins
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      axi_wr(a, d, r);
      check(r, er);
      @(posedge MCLK);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      check(d & m, e);
      check(r, er);
   endtask

   task automatic st(input upsid_state_t s);
      rd(STAT, 32'h0000_FF00, {16'h0000, s, 8'h00}, OK);
   endtask

   initial
   begin
      {SYS_RST, S_AXI_BREADY, S_AXI_RREADY, VBAT_PRESENT, IO_SUPPLY, ID_CMP_HIGH} = 6'h3F;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, CORE_SUPPLY_STABLE, SUPPLY_3V3_STABLE} = 5'h00;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 56'h0;
      {PLL_LOCK, RID_CODE, rst_req_n} = 5'h00;
      S_AXI_WSTRB = 4'hF;
      {ref_run, stp_req} = 2'h3;
      cycles(20);
      SYS_RST <= 1'b0;
      cycles(6);
      check(REG_ENABLE, 1'b0);
      check(REG_WEAK_PULLDOWN, 1'b1);
      check(PINS_HIZ, 1'b1);
      st(UPSID_ST_RESET);
      IO_SUPPLY <= 1'b0;
      cycles(4);
      check(PINS_HIZ, 1'b0);
      IO_SUPPLY <= 1'b1;
      // writes during reset mode must not land
      wr(CTRL, 32'h0000_000F, OK);
      rd(CTRL, 32'h0000_000F, 32'h0, OK);
      rst_req_n <= 1'b1;
      cycles(10);
      check(REG_ENABLE, 1'b1);
      check(REG_WEAK_PULLDOWN, 1'b0);
      check(DIR, 1'b0);
      st(UPSID_ST_POWER_UP);
      CORE_SUPPLY_STABLE <= 1'b1;
      SUPPLY_3V3_STABLE <= 1'b1;
      cycles(5);
      check(DIR, 1'b1);
      check(DATA_PULLDOWN_EN, 1'b1);
      cycles(30);
      st(UPSID_ST_LOCK_WAIT);
      PLL_LOCK <= 1'b1;
      cycles(6);
      st(UPSID_ST_STP_CHECK);
      check(DIR, 1'b1);
      stp_req <= 1'b0;
      cycles(6);
      check(SYNC_MODE, 1'b1);
      check(DIR, 1'b0);
      check(DATA_PULLDOWN_EN, 1'b0);
      rd(STAT, 32'h0000_0030, 32'h0000_0010, OK);
      for (int l = 0; l < 4; l++)
      begin
         wr(CTRL, {28'h0, 1'b1, l[1:0], 1'b0}, OK);
         check(UART_SUPPLY_LEVEL_SEL, l[1:0]);
      end
      wr(CTRL, 32'h0000_0006, OK);
      check(UART_SUPPLY_LEVEL_SEL, 2'h0);
      rd(CTRL, 32'h0000_000F, 32'h0000_0006, OK);
      rd(12'h010, 32'hFFFF_FFFF, 32'h0, ERR);
      wr(12'h010, 32'h0000_0001, ERR);
      RID_CODE <= 3'h5;
      wr(CTRL, 32'h0000_0001, OK);
      check(CABLE_ID_PULLUP_EN, 1'b1);
      check(WEAK_ID_PULLUP, 1'b0);
      rd(STAT, 32'h0000_000E, 32'h0, OK);
      snap = n_evt;
      ID_CMP_HIGH <= 1'b0;
      cycles(8);
      rd(STAT, 32'h0000_0001, 32'h0, OK);
      check(n_evt - snap, 0);
      ID_CMP_HIGH <= 1'b1;
      cycles(8);
      rd(STAT, 32'h0000_0001, 32'h1, OK);
      wr(CTRL, 32'h0000_0000, OK);
      check(WEAK_ID_PULLUP, 1'b1);
      foreach (codes[i])
      begin
         RID_CODE <= codes[i];
         cycles(4);
         rd(STAT, 32'h0000_000E, {28'h0, codes[i], 1'b0}, OK);
      end
      snap = n_evt;
      ID_CMP_HIGH <= 1'b0;
      cycles(8);
      check(n_evt - snap, 1);
      ID_CMP_HIGH <= 1'b1;
      cycles(4);
      // cycled chip reset must clear the control register
      wr(CTRL, 32'h0000_000F, OK);
      rst_req_n <= 1'b0;
      cycles(48);
      check(REG_ENABLE, 1'b0);
      check(SYNC_MODE, 1'b0);
      rst_req_n <= 1'b1;
      cycles(10);
      rd(CTRL, 32'h0000_000F, 32'h0, OK);
      check(UART_SUPPLY_LEVEL_SEL, 2'h0);
      cycles(60);
      check(SYNC_MODE, 1'b1);
      // reference already running: one power-up cycle, POR_CYC of 4, three wait states
      rd(STAT, 32'hFFFF_0000, 32'h0008_0000, OK);
      VBAT_PRESENT <= 1'b0;
      cycles(5);
      st(UPSID_ST_OFF);
      check(REG_ENABLE, 1'b0);
      end_of_test();
   end
endmodule
